//--- rtl/sadc_ctrl.v
// Operation
// - Clock select picks oscillator divide ratio.
// - Low select bits 11 pick RC clock.
// - Channel field routes input 0 to 7.
// - Writing one starts; bit reads busy.
// - Finish loads result, clears bit, flags.
// - Power bit off shuts converter down.
// - Justify set: result right justified.
// - Justify clear: result left justified.
// - Unimplemented control bits read as zero.
// - Pin field sets analog or digital pins.
// - Pin field picks reference sources.
// - Reset makes all shared pins analog.
// - Reset powers off and aborts conversion.
// - RC clock keeps converting during sleep.
// - Result built by successive approximation.
// - Conversion lasts twelve bit periods.
// - Power-on reset leaves results untouched.
`timescale 1ns/1ps
`include "sadc_regs.vh"
module sadc_ctrl (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire [4:0] awaddr,
	input wire awvalid,
	output reg awready,
	// AXI4-Lite write data
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output reg wready,
	// AXI4-Lite write response
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	// AXI4-Lite read address
	input wire [4:0] araddr,
	input wire arvalid,
	output reg arready,
	// AXI4-Lite read data
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	// Analog front end
	input wire comparator_high,
	input wire internal_rc_tick,
	input wire sleep_mode,
	output reg converter_power,
	output reg [2:0] channel_select,
	output reg sample_hold,
	output reg [9:0] dac_code,
	output reg [7:0] analog_pin_mask,
	output reg vref_pos_external,
	output reg vref_neg_external,
	// Status
	output reg conversion_busy,
	output reg conversion_done_flag
);
	localparam ST_IDLE = 2'b01;
	localparam ST_CONV = 2'b10;

	reg [1:0] clock_select_low;
	reg clock_select_high;
	reg result_justify;
	reg [3:0] pin_config_field;
	reg [7:0] result_high;
	reg [7:0] result_low;
	reg [1:0] state;
	reg [5:0] div_cnt;
	reg [3:0] tad_cnt;
	reg [9:0] trial_mask;
	reg aw_full;
	reg w_full;
	reg [4:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg [5:0] div_term;
	reg [7:0] next_mask;
	reg next_vpos;
	reg next_vneg;
	reg [31:0] rd_mux;
	reg rd_err;

	wire rc_selected = (clock_select_low == `SADC_CS_RC);
	wire do_write = aw_full & w_full & ~bvalid;
	wire wr_lane = do_write & w_strb[0];
	wire wr_ctrl0 = wr_lane & (aw_addr == {1'b0, `SADC_OFF_CTRL0});
	wire wr_ctrl1 = wr_lane & (aw_addr == {1'b0, `SADC_OFF_CTRL1});
	wire wr_status = wr_lane & (aw_addr == `SADC_OFF_STATUS_FULL);
	wire wr_mapped = (aw_addr == {1'b0, `SADC_OFF_CTRL0}) | (aw_addr == {1'b0, `SADC_OFF_CTRL1}) |
		(aw_addr == {1'b0, `SADC_OFF_RES_HIGH}) | (aw_addr == {1'b0, `SADC_OFF_RES_LOW}) |
		(aw_addr == `SADC_OFF_STATUS_FULL);
	// A start needs the converter powered and idle; a second start while busy is dropped.
	wire start = wr_ctrl0 & w_data[`SADC_C0_GO] & w_data[`SADC_C0_PWR] & (state == ST_IDLE);
	// Clearing the power bit aborts on the same edge, so busy never outlives power.
	wire abort = (state == ST_CONV) & (~converter_power | (wr_ctrl0 & ~w_data[`SADC_C0_PWR]));
	// Oscillator ticks stop in sleep, so only the RC tick can advance a conversion then.
	wire tad_tick = rc_selected ? internal_rc_tick : (~sleep_mode & (div_cnt == div_term));
	wire finish = (state == ST_CONV) & ~abort & tad_tick & (tad_cnt == `SADC_TAD_LAST);

	always @* begin
		case ({clock_select_high, clock_select_low})
			3'h0: div_term = `SADC_TERM_DIV2;
			3'h1: div_term = `SADC_TERM_DIV8;
			3'h2: div_term = `SADC_TERM_DIV32;
			3'h4: div_term = `SADC_TERM_DIV4;
			3'h5: div_term = `SADC_TERM_DIV16;
			3'h6: div_term = `SADC_TERM_DIV64;
			default: div_term = `SADC_TERM_DIV2;
		endcase
	end

	// Reference pins are taken out of the analog channel set.
	always @* begin
		next_vpos = 1'b0;
		next_vneg = 1'b0;
		case (pin_config_field)
			4'h0: next_mask = 8'hff;
			4'h1: begin next_mask = 8'hf7; next_vpos = 1'b1; end
			4'h2: next_mask = 8'h1f;
			4'h3: begin next_mask = 8'h17; next_vpos = 1'b1; end
			4'h4: next_mask = 8'h0b;
			4'h5: begin next_mask = 8'h03; next_vpos = 1'b1; end
			4'h6: next_mask = 8'h00;
			4'h7: next_mask = 8'h00;
			4'h8: begin next_mask = 8'hf3; next_vpos = 1'b1; next_vneg = 1'b1; end
			4'h9: next_mask = 8'h3f;
			4'ha: begin next_mask = 8'h37; next_vpos = 1'b1; end
			4'hb: begin next_mask = 8'h33; next_vpos = 1'b1; next_vneg = 1'b1; end
			4'hc: begin next_mask = 8'h13; next_vpos = 1'b1; next_vneg = 1'b1; end
			4'hd: begin next_mask = 8'h03; next_vpos = 1'b1; next_vneg = 1'b1; end
			4'he: next_mask = 8'h01;
			default: begin next_mask = 8'h01; next_vpos = 1'b1; next_vneg = 1'b1; end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			clock_select_low <= `SADC_CS_LO_RST;
			channel_select <= `SADC_CHAN_RST;
			converter_power <= 1'b0;
			clock_select_high <= 1'b0;
			result_justify <= 1'b0;
			pin_config_field <= `SADC_PCFG_RST;
			analog_pin_mask <= 8'hff;
			vref_pos_external <= 1'b0;
			vref_neg_external <= 1'b0;
		end else begin
			analog_pin_mask <= next_mask;
			vref_pos_external <= next_vpos;
			vref_neg_external <= next_vneg;
			if (wr_ctrl0) begin
				clock_select_low <= w_data[`SADC_C0_CS_LO];
				channel_select <= w_data[`SADC_C0_CHAN];
				converter_power <= w_data[`SADC_C0_PWR];
			end
			if (wr_ctrl1) begin
				result_justify <= w_data[`SADC_C1_JUSTIFY];
				clock_select_high <= w_data[`SADC_C1_CS_HI];
				pin_config_field <= w_data[`SADC_C1_PCFG];
			end
		end
	end

	// Conversion engine. Dropping power mid-conversion aborts it like a reset.
	always @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			div_cnt <= 6'h00;
			tad_cnt <= 4'h0;
			trial_mask <= 10'h000;
			dac_code <= 10'h000;
			sample_hold <= 1'b0;
			conversion_busy <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					div_cnt <= 6'h00;
					tad_cnt <= 4'h0;
					sample_hold <= 1'b0;
					if (start) begin
						state <= ST_CONV;
						conversion_busy <= 1'b1;
					end
				end
				ST_CONV: begin
					if (abort) begin
						state <= ST_IDLE;
						conversion_busy <= 1'b0;
					end else begin
						if (rc_selected || div_cnt == div_term)
							div_cnt <= 6'h00;
						else if (!sleep_mode)
							div_cnt <= div_cnt + 6'h01;
						if (tad_tick) begin
							tad_cnt <= tad_cnt + 4'h1;
							if (tad_cnt == 4'h0) begin
								sample_hold <= 1'b1;
								dac_code <= `SADC_MSB_TRIAL;
								trial_mask <= `SADC_MSB_TRIAL;
							end else if (tad_cnt <= `SADC_TAD_LAST_BIT) begin
								// Keep the trial bit only when the held sample is at or above it.
								dac_code <= (comparator_high ? dac_code : (dac_code & ~trial_mask)) |
									(trial_mask >> 1);
								trial_mask <= trial_mask >> 1;
							end else begin
								state <= ST_IDLE;
								conversion_busy <= 1'b0;
							end
						end
					end
				end
				default: begin
					state <= ST_IDLE;
					conversion_busy <= 1'b0;
				end
			endcase
		end
	end

	// Results carry no reset so a reset keeps the last conversion.
	always @(posedge aclk) begin
		if (finish) begin
			if (result_justify) begin
				result_high <= {6'h00, dac_code[9:8]};
				result_low <= dac_code[7:0];
			end else begin
				result_high <= dac_code[9:2];
				result_low <= {dac_code[1:0], 6'h00};
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn)
			conversion_done_flag <= 1'b0;
		else if (finish)
			conversion_done_flag <= 1'b1;
		else if (wr_status && w_data[`SADC_ST_DONE])
			conversion_done_flag <= 1'b0;
	end

	always @* begin
		rd_err = 1'b0;
		rd_mux = 32'h0000_0000;
		case (araddr)
			{1'b0, `SADC_OFF_CTRL0}: rd_mux[7:0] = {clock_select_low, channel_select, conversion_busy,
				1'b0, converter_power};
			{1'b0, `SADC_OFF_CTRL1}: rd_mux[7:0] = {result_justify, clock_select_high, 2'h0,
				pin_config_field};
			{1'b0, `SADC_OFF_RES_HIGH}: rd_mux[7:0] = result_high;
			{1'b0, `SADC_OFF_RES_LOW}: rd_mux[7:0] = result_low;
			`SADC_OFF_STATUS_FULL: rd_mux[0] = conversion_done_flag;
			default: rd_err = 1'b1;
		endcase
	end

	// AXI4-Lite slave: address and data are taken in either order, one write at a time.
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 5'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `SADC_RESP_OKAY;
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `SADC_RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_full <= 1'b1;
				awready <= 1'b0;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_full <= 1'b1;
				wready <= 1'b0;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (do_write) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_mapped ? `SADC_RESP_OKAY : `SADC_RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= rd_mux;
				rresp <= rd_err ? `SADC_RESP_SLVERR : `SADC_RESP_OKAY;
			end
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end
endmodule // sadc_ctrl

//--- rtl/sadc_regs.vh
`ifndef SADC_REGS_VH
`define SADC_REGS_VH
// Register byte offsets on the AXI4-Lite bus.
`define SADC_OFF_CTRL0 4'h0
`define SADC_OFF_CTRL1 4'h4
`define SADC_OFF_RES_HIGH 4'h8
`define SADC_OFF_RES_LOW 4'hc
`define SADC_OFF_STATUS 4'h0
`define SADC_OFF_STATUS_FULL 5'h10
// Primary control fields.
`define SADC_C0_CS_LO 7:6
`define SADC_C0_CHAN 5:3
`define SADC_C0_GO 2
`define SADC_C0_PWR 0
// Secondary control fields.
`define SADC_C1_JUSTIFY 7
`define SADC_C1_CS_HI 6
`define SADC_C1_PCFG 3:0
// Status fields.
`define SADC_ST_DONE 0
// Reset values.
`define SADC_CS_LO_RST 2'h0
`define SADC_CHAN_RST 3'h0
`define SADC_PCFG_RST 4'h0
// Clock select code that picks the internal RC clock.
`define SADC_CS_RC 2'h3
// Divider terminal counts (divisor minus one).
`define SADC_TERM_DIV2 6'h01
`define SADC_TERM_DIV4 6'h03
`define SADC_TERM_DIV8 6'h07
`define SADC_TERM_DIV16 6'h0f
`define SADC_TERM_DIV32 6'h1f
`define SADC_TERM_DIV64 6'h3f
// Conversion timing in bit periods, and the first trial code.
`define SADC_TAD_FIRST_BIT 4'h1
`define SADC_TAD_LAST_BIT 4'ha
`define SADC_TAD_LAST 4'hb
`define SADC_MSB_TRIAL 10'h200
// AXI responses.
`define SADC_RESP_OKAY 2'h0
`define SADC_RESP_SLVERR 2'h2
`endif

//--- sim/sadc_ctrl_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t %h %h", $time, a, b); end end
module sadc_ctrl_bench;
	localparam int RC_DIV = 7;
	// The model stands for the eight-input package; a smaller one lowers this.
	localparam int INPUTS = 8;
	localparam logic [127:0] PMASK = 128'hfff71f170b030000f33f373313030101;
	localparam logic [15:0] VPOS = 16'hbd2a;
	localparam logic [15:0] VNEG = 16'hb900;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, sleep_mode = 0;
	logic [4:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [1:0] bresp, rresp, resp;
	logic awready, wready, bvalid, arready, rvalid, comparator_high, internal_rc_tick, rc_sel = 0;
	logic converter_power, sample_hold, vref_pos_external, vref_neg_external, conversion_busy, conversion_done_flag;
	logic [2:0] channel_select;
	logic [9:0] dac_code;
	logic [7:0] analog_pin_mask;
	int error_cnt = 0, checks = 0, ticks = 0, t0;
	always #25 aclk = ~aclk;
	sadc_ctrl DUT (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.comparator_high(comparator_high), .internal_rc_tick(internal_rc_tick), .sleep_mode(sleep_mode),
		.converter_power(converter_power), .channel_select(channel_select), .sample_hold(sample_hold),
		.dac_code(dac_code), .analog_pin_mask(analog_pin_mask), .vref_pos_external(vref_pos_external),
		.vref_neg_external(vref_neg_external), .conversion_busy(conversion_busy),
		.conversion_done_flag(conversion_done_flag)
	);
	sadc_front_model #(.RC_DIV(RC_DIV)) u_front (
		.aclk(aclk), .channel_select(channel_select), .dac_code(dac_code),
		.comparator_high(comparator_high), .internal_rc_tick(internal_rc_tick)
	);
	// Counts clock cycles of the running conversion, or RC ticks when the RC clock is selected.
	always @(posedge aclk) if (conversion_busy && (!rc_sel || internal_rc_tick)) ticks <= ticks + 1;
	task do_reset;
		@(posedge aclk);
		aresetn <= 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1;
	endtask
	task wr(input [4:0] a, input [7:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (awvalid && !awready || wvalid && !wready);
		while (!bvalid) @(posedge aclk);
		bready <= 0;
		resp = bresp;
	endtask
	task rchk(input [4:0] a, input [7:0] e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		do @(posedge aclk); while (!rvalid);
		rready <= 0;
		resp = rresp;
		`CHK(rdata, {24'h0, e})
	endtask
	task t_regs;
		rchk(5'h0, 8'h00);
		rchk(5'h4, 8'h00);
		`CHK(analog_pin_mask, 8'hff)
		// Start and the unused bit are set while power stays off: nothing may start.
		wr(5'h0, 8'hfe);
		rchk(5'h0, 8'hf8);
		`CHK(conversion_busy, 1'b0)
		`CHK(channel_select, 3'h7)
		wr(5'h4, 8'hff);
		rchk(5'h4, 8'hcf);
		wr(5'h14, 8'h01);
		`CHK(resp, 2'h2)
		rchk(5'h14, 8'h00);
		`CHK(resp, 2'h2)
	endtask
	task t_pins;
		for (int k = 0; k < 16; k++) begin
			wr(5'h4, k[7:0]);
			@(negedge aclk);
			`CHK(analog_pin_mask, PMASK[127 - 8 * k -: 8])
			`CHK({vref_pos_external, vref_neg_external}, {VPOS[k], VNEG[k]})
		end
	endtask
	task t_conv(input [2:0] cs, input [2:0] ch, input j);
		logic [9:0] lv;
		int n;
		lv = {ch, 7'h2b};
		n = 2 << (2 * cs[1:0] + cs[2]);
		rc_sel = (cs[1:0] == 2'b11);
		if (rc_sel) n = 1;
		wr(5'h4, {j, cs[2], 6'h0});
		wr(5'h0, {cs[1:0], ch, 3'b001});
		wr(5'h0, {cs[1:0], ch, 3'b101});
		t0 = ticks;
		rchk(5'h0, {cs[1:0], ch, 3'b101});
		while (conversion_busy) @(posedge aclk);
		`CHK(ticks - t0, 12 * n)
		`CHK(conversion_done_flag, 1'b1)
		rchk(5'h0, {cs[1:0], ch, 3'b001});
		rchk(5'h8, j ? {6'h0, lv[9:8]} : lv[9:2]);
		rchk(5'hc, j ? lv[7:0] : {lv[1:0], 6'h0});
		rchk(5'h10, 8'h01);
		wr(5'h10, 8'h01);
		rchk(5'h10, 8'h00);
		repeat (2 * (rc_sel ? RC_DIV : n)) @(posedge aclk);
	endtask
	task t_abort;
		wr(5'h4, 8'h40);
		wr(5'h0, 8'h95);
		wr(5'h0, 8'h90);
		`CHK({conversion_busy, converter_power}, 2'b00)
		rchk(5'h10, 8'h00);
		wr(5'h0, 8'h95);
		do_reset;
		`CHK(conversion_busy, 1'b0)
		rchk(5'h0, 8'h00);
	endtask
	// Divider-based bit periods must freeze in sleep and resume on wake.
	task t_sleep_div;
		wr(5'h4, 8'h00);
		wr(5'h0, 8'h01);
		sleep_mode <= 1;
		wr(5'h0, 8'h05);
		repeat (48) @(posedge aclk);
		`CHK(conversion_busy, 1'b1)
		sleep_mode <= 0;
		repeat (30) @(posedge aclk);
		`CHK(conversion_busy, 1'b0)
		`CHK(conversion_done_flag, 1'b1)
		wr(5'h10, 8'h01);
	endtask
	task report_and_stop;
		if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		do_reset;
		t_regs;
		t_pins;
		// Inputs that the package lacks are never selected.
		for (int c = 0; c < 8; c++) t_conv(c[2:0], (c < INPUTS) ? c[2:0] : 3'h0, c[0]);
		sleep_mode <= 1;
		// Only the RC clock may run in sleep, so divider codes are kept out here.
		t_conv(3'b011, 3'h6, 1'b0);
		sleep_mode <= 0;
		t_sleep_div;
		t_abort;
		report_and_stop;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		report_and_stop;
	end
endmodule // sadc_ctrl_bench

//--- sim/sadc_ctrl_monitor.sv
`timescale 1ns/1ps
module sadc_ctrl_monitor (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Bus handshakes
	input wire bvalid,
	input wire bready,
	input wire rvalid,
	input wire rready,
	// Converter side
	input wire converter_power,
	input wire sample_hold,
	input wire [9:0] dac_code,
	input wire [7:0] analog_pin_mask,
	input wire vref_pos_external,
	input wire vref_neg_external,
	input wire conversion_busy,
	input wire conversion_done_flag
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rst; $rose(aresetn) |-> analog_pin_mask == 8'hff && !converter_power && !conversion_busy; endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_done; $fell(conversion_busy) && converter_power |-> conversion_done_flag; endproperty
	a_done: assert property (p_done) else $error("finish without flag");
	property p_hold; $rose(sample_hold) |-> conversion_busy && dac_code == 10'h200; endproperty
	a_hold: assert property (p_hold) else $error("bad first trial");
	property p_pwr; conversion_busy |-> converter_power; endproperty
	a_pwr: assert property (p_pwr) else $error("busy while unpowered");
	property p_vpos; vref_pos_external |-> !analog_pin_mask[3]; endproperty
	a_vpos: assert property (p_vpos) else $error("reference pin analog");
	property p_vneg; vref_neg_external |-> vref_pos_external && !analog_pin_mask[2]; endproperty
	a_vneg: assert property (p_vneg) else $error("bad negative reference");
	property p_clr; $fell(conversion_done_flag) |-> $rose(bvalid); endproperty
	a_clr: assert property (p_clr) else $error("flag lost");
	property p_bresp; bvalid && bready |=> !bvalid; endproperty
	a_bresp: assert property (p_bresp) else $error("write answer repeated");
	property p_rresp; rvalid && rready |=> !rvalid; endproperty
	a_rresp: assert property (p_rresp) else $error("read answer repeated");
endmodule // sadc_ctrl_monitor

bind sadc_ctrl sadc_ctrl_monitor u_mon (.aclk, .aresetn, .bvalid, .bready, .rvalid, .rready, .converter_power,
	.sample_hold, .dac_code, .analog_pin_mask, .vref_pos_external, .vref_neg_external, .conversion_busy,
	.conversion_done_flag);

//--- sim/sadc_front_model.sv
`timescale 1ns/1ps
module sadc_front_model #(parameter int RC_DIV = 7) (
	input wire aclk,
	input wire [2:0] channel_select,
	input wire [9:0] dac_code,
	output logic comparator_high,
	output logic internal_rc_tick = 1'b0
);
	int rc_cnt = 0;
	// The RC oscillator has its own source, so sleep never stops it.
	always @(posedge aclk) begin
		rc_cnt <= (rc_cnt == RC_DIV - 1) ? 0 : rc_cnt + 1;
		internal_rc_tick <= (rc_cnt == RC_DIV - 1);
	end
	// Each input holds its own level so a wrong channel shows in the result.
	assign comparator_high = {channel_select, 7'h2b} >= dac_code;
endmodule // sadc_front_model
